// *** rtl/dpf_pkg.sv ***
// Shared constants for the digital port function configuration block
package dpf_pkg;
    // Port register frame in the peripheral file
    localparam logic [15:0] FRAME_LO = 16'h1020;
    localparam logic [15:0] FRAME_HI = 16'h102F;
    localparam logic [15:0] ADDR_A_FSH = 16'h1021;
    localparam logic [15:0] ADDR_A_VAL = 16'h1022;
    localparam logic [15:0] ADDR_A_DIR = 16'h1023;
    localparam logic [15:0] ADDR_B_FSH = 16'h1025;
    localparam logic [15:0] ADDR_B_VAL = 16'h1026;
    localparam logic [15:0] ADDR_B_DIR = 16'h1027;
    localparam logic [15:0] ADDR_C_FSH = 16'h1029;
    localparam logic [15:0] ADDR_C_VAL = 16'h102A;
    localparam logic [15:0] ADDR_C_DIR = 16'h102B;
    localparam logic [15:0] ADDR_D_FSL = 16'h102C;
    localparam logic [15:0] ADDR_D_FSH = 16'h102D;
    localparam logic [15:0] ADDR_D_VAL = 16'h102E;
    localparam logic [15:0] ADDR_D_DIR = 16'h102F;
    // Eighth-space chip select window
    localparam logic [15:0] CSE_LO = 16'h2000;
    localparam logic [15:0] CSE_HI = 16'h3FFF;
    // Reset values and the forced microprocessor-mode select value
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] UPRO_FSEL = 8'hFF;
    // Pin positions of the port D control signals
    localparam int PIN_CSE = 7;
    localparam int PIN_RW = 4;
    // Port indices
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    // Function select encoding {low, high}
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_FUNC_A = 2'h1;
    localparam logic [1:0] SEL_FUNC_B = 2'h3;
    // Start-up sequencer states
    typedef enum logic [1:0] {
        ST_SYNC1 = 2'b00,
        ST_SYNC2 = 2'b01,
        ST_LOAD = 2'b10,
        ST_RUN = 2'b11
    } dpf_init_e;
endpackage : dpf_pkg

// *** rtl/dpf_sync.sv ***
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module dpf_sync #(
    parameter int W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // First stage feeds only the second stage
    always_comb begin
        next_meta = ce_i ? d_i : meta;
        next_q = ce_i ? meta : q_o;
    end

    // Both stages freeze with the clock enable
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : dpf_sync

// *** rtl/dpf_port_mux.sv ***
// Per-pin function multiplexer for one 8-bit port
`timescale 1ns/1ns
module dpf_port_mux #(
    parameter int PORT = 0
) (
    input wire logic [7:0] fsel_low_i,
    input wire logic [7:0] fsel_high_i,
    input wire logic [7:0] value_i,
    input wire logic [7:0] dir_i,
    input wire logic [15:0] exp_addr_i,
    input wire logic [7:0] exp_wdata_i,
    input wire logic exp_rw_i,
    input wire logic exp_active_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o
);
    logic cse_hit;

    // Eighth-space window hit during an active external cycle
    assign cse_hit = exp_active_i && (exp_addr_i >= dpf_pkg::CSE_LO) && (exp_addr_i <= dpf_pkg::CSE_HI);

    for (genvar i = 0; i < 8; i++) begin : g_pin
        // One selection per pin, so unused pins stay plain I/O
        always_comb begin
            pin_o[i] = 1'b0;
            pin_oe_o[i] = 1'b0;
            case ({fsel_low_i[i], fsel_high_i[i]})
                dpf_pkg::SEL_GPIO: begin
                    // Value drives, direction enables
                    pin_o[i] = value_i[i];
                    pin_oe_o[i] = dir_i[i];
                end
                dpf_pkg::SEL_FUNC_A, dpf_pkg::SEL_FUNC_B: begin
                    if (PORT == dpf_pkg::PORT_A) begin
                        // Data bus ignores value and direction bits
                        pin_o[i] = exp_wdata_i[i];
                        pin_oe_o[i] = exp_active_i && !exp_rw_i;
                    end else if (PORT == dpf_pkg::PORT_B) begin
                        // Low address byte, output only
                        pin_o[i] = exp_addr_i[i];
                        pin_oe_o[i] = 1'b1;
                    end else if (PORT == dpf_pkg::PORT_C) begin
                        // High address byte, output only
                        pin_o[i] = exp_addr_i[8+i];
                        pin_oe_o[i] = 1'b1;
                    end else if (fsel_low_i[i] == 1'b0 && i == dpf_pkg::PIN_CSE) begin
                        // Chip select is active low
                        pin_o[i] = !cse_hit;
                        pin_oe_o[i] = 1'b1;
                    end else if (fsel_low_i[i] == 1'b0 && i == dpf_pkg::PIN_RW) begin
                        // High for read, low for write
                        pin_o[i] = exp_rw_i;
                        pin_oe_o[i] = 1'b1;
                    end else begin
                        // Other port D bus signals are not built here: pin floats
                        pin_o[i] = 1'b0;
                        pin_oe_o[i] = 1'b0;
                    end
                end
                default: begin
                    // Undefined select code leaves the pin floating
                    pin_o[i] = 1'b0;
                    pin_oe_o[i] = 1'b0;
                end
            endcase
        end
    end
endmodule : dpf_port_mux

// *** rtl/dpf_top.sv ***
// Digital port function configuration: registers, start-up mode and pin drive
`timescale 1ns/1ns
// Behaviour
// - Microcomputer mode start makes all pins floating inputs
// - Microprocessor start sets every select bit: function B on port D, function A on ports A to C
// - Software selects output, input, function A or B
// - Bus signals enabled per pin, rest stay I/O
// - Memory disabled: port frame accesses go external
// - Registers decoded at their fixed peripheral-file addresses
// - Port A high select bit makes data bus
// - Port D bit 7 function A: eighth-space select
// - Port D bit 4 function A: read/write line
// - Variants without expansion only start in microcomputer mode
// - Bit n of each register controls pin n
// - Select codes: 00 I/O, 01 A, 11 B
module dpf_top #(
    parameter bit HAS_BUS_EXP = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic upro_strap_i,
    input wire logic int_mem_dis_i,
    input wire logic [15:0] pf_addr_i,
    input wire logic pf_wr_i,
    input wire logic pf_rd_i,
    input wire logic [7:0] pf_wdata_i,
    output logic [7:0] pf_rdata_o,
    output logic ext_access_o,
    output logic upro_mode_o,
    input wire logic [15:0] exp_addr_i,
    input wire logic [7:0] exp_wdata_i,
    input wire logic exp_rw_i,
    input wire logic exp_active_i,
    input wire logic [7:0] port_a_pin_i,
    output logic [7:0] port_a_pin_o,
    output logic [7:0] port_a_pin_oe_o,
    input wire logic [7:0] port_b_pin_i,
    output logic [7:0] port_b_pin_o,
    output logic [7:0] port_b_pin_oe_o,
    input wire logic [7:0] port_c_pin_i,
    output logic [7:0] port_c_pin_o,
    output logic [7:0] port_c_pin_oe_o,
    input wire logic [7:0] port_d_pin_i,
    output logic [7:0] port_d_pin_o,
    output logic [7:0] port_d_pin_oe_o
);
    dpf_pkg::dpf_init_e st;
    dpf_pkg::dpf_init_e next_st;
    logic upro_take;
    logic next_upro_mode;
    logic strap_sync;
    logic [31:0] pin_in_sync; // Synchronised pin levels, port A in the low byte
    logic [3:0][7:0] fsel_high; // Second select per port
    logic [7:0] fsel_low_d; // First select, port D only
    logic [3:0][7:0] value; // Stored output values
    logic [3:0][7:0] dir; // Directions, 1 = output
    logic [3:0][7:0] next_fsel_high;
    logic [7:0] next_fsel_low_d;
    logic [3:0][7:0] next_value;
    logic [3:0][7:0] next_dir;
    logic [3:0][7:0] fsel_low; // Zero for ports without a first select
    logic [3:0][7:0] mux_o;
    logic [3:0][7:0] mux_oe;
    logic in_frame;
    logic int_acc; // Access served by the internal registers
    logic [7:0] rd_mux;
    logic [7:0] next_rdata;
    logic next_ext;

    // Strap and pins come from outside and are synchronised
    dpf_sync #(.W(1)) u_strap_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i(upro_strap_i),
        .q_o(strap_sync)
    );
    dpf_sync #(.W(32)) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i({port_d_pin_i, port_c_pin_i, port_b_pin_i, port_a_pin_i}),
        .q_o(pin_in_sync)
    );

    // Variants without expansion never honour the strap
    assign upro_take = HAS_BUS_EXP && strap_sync;

    // Start-up sequencer: wait for the strap to pass the synchroniser, then load
    // The strap is looked at once, in LOAD; a later change waits for the next reset
    always_comb begin
        next_st = st;
        next_upro_mode = upro_mode_o;
        if (ce_i) begin
            case (st)
                dpf_pkg::ST_SYNC1: next_st = dpf_pkg::ST_SYNC2;
                dpf_pkg::ST_SYNC2: next_st = dpf_pkg::ST_LOAD;
                dpf_pkg::ST_LOAD: begin
                    next_st = dpf_pkg::ST_RUN;
                    next_upro_mode = upro_take;
                end
                dpf_pkg::ST_RUN: next_st = dpf_pkg::ST_RUN;
                default: next_st = dpf_pkg::ST_SYNC1;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= dpf_pkg::ST_SYNC1;
            upro_mode_o <= 1'b0;
        end else begin
            st <= next_st;
            upro_mode_o <= next_upro_mode;
        end
    end

    // Accesses made before start-up has finished are ignored on purpose
    // Frame decode; with internal memory off the frame belongs to the outside
    assign in_frame = (pf_addr_i >= dpf_pkg::FRAME_LO) && (pf_addr_i <= dpf_pkg::FRAME_HI);
    assign int_acc = in_frame && !int_mem_dis_i && (st == dpf_pkg::ST_RUN);

    // Register writes; writes during start-up are dropped
    // Unmapped frame slots are simply ignored, no error is raised
    always_comb begin
        next_fsel_high = fsel_high;
        next_fsel_low_d = fsel_low_d;
        next_value = value;
        next_dir = dir;
        if (ce_i && st == dpf_pkg::ST_LOAD && upro_take) begin
            // Every select bit forced: function B on port D pins, function A on ports A to C
            next_fsel_high = {4{dpf_pkg::UPRO_FSEL}};
            next_fsel_low_d = dpf_pkg::UPRO_FSEL;
        end else if (ce_i && int_acc && pf_wr_i) begin
            case (pf_addr_i)
                dpf_pkg::ADDR_A_FSH: next_fsel_high[dpf_pkg::PORT_A] = pf_wdata_i;
                dpf_pkg::ADDR_A_VAL: next_value[dpf_pkg::PORT_A] = pf_wdata_i;
                dpf_pkg::ADDR_A_DIR: next_dir[dpf_pkg::PORT_A] = pf_wdata_i;
                dpf_pkg::ADDR_B_FSH: next_fsel_high[dpf_pkg::PORT_B] = pf_wdata_i;
                dpf_pkg::ADDR_B_VAL: next_value[dpf_pkg::PORT_B] = pf_wdata_i;
                dpf_pkg::ADDR_B_DIR: next_dir[dpf_pkg::PORT_B] = pf_wdata_i;
                dpf_pkg::ADDR_C_FSH: next_fsel_high[dpf_pkg::PORT_C] = pf_wdata_i;
                dpf_pkg::ADDR_C_VAL: next_value[dpf_pkg::PORT_C] = pf_wdata_i;
                dpf_pkg::ADDR_C_DIR: next_dir[dpf_pkg::PORT_C] = pf_wdata_i;
                dpf_pkg::ADDR_D_FSL: next_fsel_low_d = pf_wdata_i;
                dpf_pkg::ADDR_D_FSH: next_fsel_high[dpf_pkg::PORT_D] = pf_wdata_i;
                dpf_pkg::ADDR_D_VAL: next_value[dpf_pkg::PORT_D] = pf_wdata_i;
                dpf_pkg::ADDR_D_DIR: next_dir[dpf_pkg::PORT_D] = pf_wdata_i;
                default: next_value = value; // Unused frame slots ignore writes
            endcase
        end
    end

    // Reset leaves every pin a floating general-purpose input
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsel_high <= {4{dpf_pkg::RST_REG}};
            fsel_low_d <= dpf_pkg::RST_REG;
            value <= {4{dpf_pkg::RST_REG}};
            dir <= {4{dpf_pkg::RST_REG}};
        end else begin
            fsel_high <= next_fsel_high;
            fsel_low_d <= next_fsel_low_d;
            value <= next_value;
            dir <= next_dir;
        end
    end

    // Only port D has a first select register
    assign fsel_low = {fsel_low_d, 24'h000000};

    // One multiplexer per port, bit n steering pin n
    for (genvar p = 0; p < 4; p++) begin : g_port
        dpf_port_mux #(.PORT(p)) u_mux (
            .fsel_low_i(fsel_low[p]),
            .fsel_high_i(fsel_high[p]),
            .value_i(value[p]),
            .dir_i(dir[p]),
            .exp_addr_i(exp_addr_i),
            .exp_wdata_i(exp_wdata_i),
            .exp_rw_i(exp_rw_i),
            .exp_active_i(exp_active_i),
            .pin_o(mux_o[p]),
            .pin_oe_o(mux_oe[p])
        );
    end

    // Read mux: an input pin returns its live level, any other the stored bit
    // Reads never change state, so polling a port is always safe
    always_comb begin
        rd_mux = 8'h00;
        for (int p = 0; p < 4; p++) begin
            if (pf_addr_i == dpf_pkg::ADDR_A_FSH + 16'(4 * p)) begin
                rd_mux = fsel_high[p];
            end else if (pf_addr_i == dpf_pkg::ADDR_A_VAL + 16'(4 * p)) begin
                rd_mux = (value[p] & (dir[p] | fsel_high[p] | fsel_low[p]))
                    | (pin_in_sync[8*p +: 8] & ~(dir[p] | fsel_high[p] | fsel_low[p]));
            end else if (pf_addr_i == dpf_pkg::ADDR_A_DIR + 16'(4 * p)) begin
                rd_mux = dir[p];
            end
        end
        if (pf_addr_i == dpf_pkg::ADDR_D_FSL) begin
            rd_mux = fsel_low_d;
        end
    end

    // Read data holds until the next read; external frame accesses are flagged
    always_comb begin
        next_rdata = pf_rdata_o;
        next_ext = ext_access_o;
        if (ce_i) begin
            next_ext = in_frame && int_mem_dis_i && (pf_rd_i || pf_wr_i);
            if (int_acc && pf_rd_i) begin
                next_rdata = rd_mux;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pf_rdata_o <= 8'h00;
            ext_access_o <= 1'b0;
        end else begin
            pf_rdata_o <= next_rdata;
            ext_access_o <= next_ext;
        end
    end

    // Pin drivers are registered so the pads never see mux glitches
    // The clock enable freezes the pads too, so a halted core leaves them steady
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_pin_o <= 8'h00;
            port_a_pin_oe_o <= 8'h00;
            port_b_pin_o <= 8'h00;
            port_b_pin_oe_o <= 8'h00;
            port_c_pin_o <= 8'h00;
            port_c_pin_oe_o <= 8'h00;
            port_d_pin_o <= 8'h00;
            port_d_pin_oe_o <= 8'h00;
        end else if (ce_i) begin
            port_a_pin_o <= mux_o[dpf_pkg::PORT_A];
            port_a_pin_oe_o <= mux_oe[dpf_pkg::PORT_A];
            port_b_pin_o <= mux_o[dpf_pkg::PORT_B];
            port_b_pin_oe_o <= mux_oe[dpf_pkg::PORT_B];
            port_c_pin_o <= mux_o[dpf_pkg::PORT_C];
            port_c_pin_oe_o <= mux_oe[dpf_pkg::PORT_C];
            port_d_pin_o <= mux_o[dpf_pkg::PORT_D];
            port_d_pin_oe_o <= mux_oe[dpf_pkg::PORT_D];
        end
    end

    // Checks run on the core clock and are switched off while reset is low
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_load_ucom;
        ce_i && st == dpf_pkg::ST_LOAD && !upro_take;
    endsequence
    sequence s_quiet;
        ce_i && !(int_acc && pf_wr_i);
    endsequence

    a_ucom_all_input: assert property (s_load_ucom ##1 s_quiet |=> port_a_pin_oe_o == 8'h00
        && port_b_pin_oe_o == 8'h00 && port_c_pin_oe_o == 8'h00 && port_d_pin_oe_o == 8'h00)
        else $error("pins not floating after microcomputer start");
    a_upro_func_b: assert property (ce_i && st == dpf_pkg::ST_LOAD && upro_take |=>
        fsel_high == {4{dpf_pkg::UPRO_FSEL}} && fsel_low_d == dpf_pkg::UPRO_FSEL && upro_mode_o)
        else $error("microprocessor start did not force function B");
    a_sel_write: assert property (ce_i && int_acc && pf_wr_i && pf_addr_i == dpf_pkg::ADDR_C_FSH |=>
        fsel_high[dpf_pkg::PORT_C] == $past(pf_wdata_i))
        else $error("select write lost");
    a_gpio_out: assert property (ce_i && fsel_low_d[0] == 1'b0 && fsel_high[3][0] == 1'b0 && dir[3][0] |=>
        port_d_pin_oe_o[0] && port_d_pin_o[0] == $past(value[3][0]))
        else $error("general-purpose output not driven");
    a_ext_frame: assert property (ce_i && in_frame && int_mem_dis_i && pf_wr_i |=>
        ext_access_o && value == $past(value) && dir == $past(dir))
        else $error("frame access not routed outside");
    a_decode_low: assert property (ce_i && int_acc && pf_wr_i && pf_addr_i == dpf_pkg::ADDR_D_FSL |=>
        fsel_low_d == $past(pf_wdata_i) && $stable(fsel_high))
        else $error("first select decode wrong");
    a_data_bus: assert property (ce_i && fsel_high[0][0] && exp_active_i && !exp_rw_i |=>
        port_a_pin_oe_o[0] && port_a_pin_o[0] == $past(exp_wdata_i[0]))
        else $error("data bus pin not driving write data");
    a_cse_select: assert property (ce_i && !fsel_low_d[7] && fsel_high[3][7] |=>
        port_d_pin_oe_o[7] && port_d_pin_o[7] == !$past(exp_active_i && exp_addr_i >= dpf_pkg::CSE_LO
        && exp_addr_i <= dpf_pkg::CSE_HI))
        else $error("eighth-space select wrong");
    a_rw_line: assert property (ce_i && !fsel_low_d[4] && fsel_high[3][4] |=>
        port_d_pin_oe_o[4] && port_d_pin_o[4] == $past(exp_rw_i))
        else $error("read/write line wrong");
    a_no_expansion: assert property (!HAS_BUS_EXP && ce_i && st == dpf_pkg::ST_LOAD |=>
        !upro_mode_o && fsel_high == {4{dpf_pkg::RST_REG}})
        else $error("expansion mode entered on plain variant");
    a_read_input: assert property (ce_i && int_acc && pf_rd_i && pf_addr_i == dpf_pkg::ADDR_B_VAL
        && dir[1] == 8'h00 && fsel_high[1] == 8'h00 |=> pf_rdata_o == $past(pin_in_sync[15:8]))
        else $error("input pin read not live");
endmodule : dpf_top

// *** test/dpf_ext_mem.sv ***
// Behavioural external memory hanging on the expansion bus pins
`timescale 1ns/1ns
module dpf_ext_mem (
    input wire logic core_clk_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic cs_n_i,
    input wire logic rw_i,
    output logic [7:0] data_o
);
    // 2 KB array, decoded by the low eleven address lines only
    logic [7:0] mem [0:2047];
    // Last byte shown; inverted when released so stale data never passes for a match
    logic [7:0] last = 8'h00;
    // Store on write cycles only while selected
    always_ff @(posedge core_clk_i) begin
        if (!cs_n_i && !rw_i) begin
            mem[addr_i[10:0]] <= data_i;
        end
        last <= data_o;
    end
    // Answer selected reads, otherwise a pattern that changes every cycle
    assign data_o = (!cs_n_i && rw_i) ? mem[addr_i[10:0]] : ~last;
endmodule : dpf_ext_mem

// *** test/tb_top.sv ***
// Self-checking bench for the port function configuration block
`timescale 1ns/1ns
module tb_top;
    // Register row: write flag, address, data, expected read
    typedef struct {bit w; logic [15:0] a; logic [7:0] d; logic [7:0] e;} dpf_row_s;
    logic clk = 1'b0, rst_n = 1'b0, strap = 1'b0, dis = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
    logic exp_rw = 1'b1, exp_act = 1'b0;
    logic [15:0] addr = 16'h0000, exp_addr = 16'h0000;
    logic [7:0] wdata = 8'h00, exp_wd = 8'h00, rdata, mdl_d;
    logic ext_acc, upro, upro_plain;
    logic [7:0] a_o, a_oe, b_o, b_oe, c_o, c_oe, d_o, d_oe;
    int fails = 0, check_count = 0;
    // Undriven pads fall back to fixed levels; port A to the memory
    wire [7:0] a_l = (a_oe & a_o) | (~a_oe & mdl_d);
    wire [7:0] b_l = (b_oe & b_o) | (~b_oe & 8'h5A);
    wire [7:0] c_l = (c_oe & c_o) | (~c_oe & 8'hC3);
    wire [7:0] d_l = (d_oe & d_o) | (~d_oe & 8'h96);
    // Ordinary register cases; value is loaded before direction
    dpf_row_s rows [22] = '{'{1, 16'h1026, 8'h33, 8'h5A}, '{1, 16'h1027, 8'hFF, 8'hFF}, '{0, 16'h1026, 8'h00, 8'h33},
        '{1, 16'h1021, 8'h80, 8'h80}, '{1, 16'h1021, 8'h00, 8'h00}, '{1, 16'h1023, 8'hA5, 8'hA5},
        '{1, 16'h1025, 8'h81, 8'h81}, '{1, 16'h1025, 8'h00, 8'h00}, '{1, 16'h1029, 8'h3C, 8'h3C},
        '{1, 16'h102A, 8'h77, 8'hF7}, '{1, 16'h102B, 8'hC3, 8'hC3}, '{0, 16'h102A, 8'h00, 8'h77},
        '{1, 16'h1029, 8'h00, 8'h00},
        '{1, 16'h102C, 8'h00, 8'h00}, '{1, 16'h102D, 8'h66, 8'h66}, '{1, 16'h102D, 8'h00, 8'h00},
        '{1, 16'h102E, 8'hAA, 8'h96}, '{1, 16'h102F, 8'h0F, 8'h0F}, '{0, 16'h102E, 8'h00, 8'h9A},
        '{1, 16'h1020, 8'h12, 8'h00},
        '{1, 16'h1024, 8'h34, 8'h00}, '{1, 16'h1028, 8'h56, 8'h00}};
    // Expanded set-up: address in the top two bytes, data in the low byte
    logic [23:0] setup [8] = '{24'h1021FF, 24'h1025FF, 24'h102907, 24'h102B00, 24'h102C00, 24'h102E6F,
        24'h102FFF, 24'h102D90};
    logic [15:0] fsel [5] = '{16'h1021, 16'h1025, 16'h1029, 16'h102C, 16'h102D};

    // Free-running core clock
    always #5 clk = ~clk;

    dpf_top u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .upro_strap_i(strap), .int_mem_dis_i(dis),
        .pf_addr_i(addr), .pf_wr_i(wr), .pf_rd_i(rd), .pf_wdata_i(wdata), .pf_rdata_o(rdata),
        .ext_access_o(ext_acc), .upro_mode_o(upro), .exp_addr_i(exp_addr), .exp_wdata_i(exp_wd),
        .exp_rw_i(exp_rw), .exp_active_i(exp_act), .port_a_pin_i(a_l), .port_a_pin_o(a_o),
        .port_a_pin_oe_o(a_oe), .port_b_pin_i(b_l), .port_b_pin_o(b_o), .port_b_pin_oe_o(b_oe),
        .port_c_pin_i(c_l), .port_c_pin_o(c_o), .port_c_pin_oe_o(c_oe), .port_d_pin_i(d_l),
        .port_d_pin_o(d_o), .port_d_pin_oe_o(d_oe));
    dpf_ext_mem u_mem (.core_clk_i(clk), .addr_i({c_l, b_l}), .data_i(a_l), .cs_n_i(d_l[7]), .rw_i(d_l[4]),
        .data_o(mdl_d));
    // Variant without expansion sees the same strap and must stay in microcomputer mode
    dpf_top #(.HAS_BUS_EXP(1'b0)) u_dut_plain (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .upro_strap_i(strap),
        .int_mem_dis_i(dis), .pf_addr_i(addr), .pf_wr_i(wr), .pf_rd_i(rd), .pf_wdata_i(wdata), .pf_rdata_o(),
        .ext_access_o(), .upro_mode_o(upro_plain), .exp_addr_i(exp_addr), .exp_wdata_i(exp_wd), .exp_rw_i(exp_rw),
        .exp_active_i(exp_act), .port_a_pin_i(a_l), .port_a_pin_o(), .port_a_pin_oe_o(), .port_b_pin_i(b_l),
        .port_b_pin_o(), .port_b_pin_oe_o(), .port_c_pin_i(c_l), .port_c_pin_o(), .port_c_pin_oe_o(),
        .port_d_pin_i(d_l), .port_d_pin_o(), .port_d_pin_oe_o());

    // Byte compare; case inequality so an unknown never matches
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One write strobe, taken at the second edge
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // One read strobe; data is settled by the following falling edge
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask : rd_reg
    // Reset held three cycles, then start-up must reach the run state
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : do_reset
    // Pins are registered, so let two edges pass before looking
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // Single place where the run ends
    task automatic results();
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        #100000;
        fails++;
        results();
    end

    // Main sequence
    initial begin
        do_reset();
        chk(a_oe | b_oe | c_oe | d_oe, 8'h00);
        chk({7'h0, upro}, 8'h00);
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rows[i].e);
        end
        settle();
        chk(b_oe, 8'hFF);
        chk(b_o, 8'h33);
        chk(c_oe, 8'hC3);
        chk(d_o & 8'h0F, 8'h0A);
        // Frame access with internal memory off goes outside
        @(posedge clk);
        dis <= 1'b1;
        wr_reg(16'h1026, 8'h44);
        @(negedge clk);
        chk({7'h0, ext_acc}, 8'h01);
        @(posedge clk);
        dis <= 1'b0;
        @(negedge clk);
        chk({7'h0, ext_acc}, 8'h00);
        rd_reg(16'h1026, 8'h33);
        // Undefined select code leaves the pin floating
        wr_reg(16'h102C, 8'h08);
        settle();
        chk(d_oe, 8'h07);
        wr_reg(16'h102C, 8'h00);
        // Expanded set-up, then an external write inside the eighth space
        foreach (setup[i]) wr_reg(setup[i][23:8], setup[i][7:0]);
        exp_addr <= 16'h2005;
        exp_wd <= 8'hA5;
        exp_rw <= 1'b0;
        exp_act <= 1'b1;
        settle();
        chk(a_oe, 8'hFF);
        chk(a_o, 8'hA5);
        chk(b_o, 8'h05);
        chk(c_oe, 8'h07);
        chk(d_oe, 8'hFF);
        chk(d_o, 8'h6F);
        chk(u_mem.mem[11'h005], 8'hA5);
        // Same low address outside the eighth space must not select
        @(posedge clk);
        exp_addr <= 16'h4005;
        exp_wd <= 8'h5C;
        settle();
        chk(d_o, 8'hEF);
        chk(u_mem.mem[11'h005], 8'hA5);
        // Read cycle releases the data bus and raises the direction line
        @(posedge clk);
        exp_rw <= 1'b1;
        settle();
        chk(a_oe, 8'h00);
        chk(d_o & 8'h10, 8'h10);
        @(posedge clk);
        exp_act <= 1'b0;
        // Second reset with the strap high
        strap <= 1'b1;
        do_reset();
        chk({7'h0, upro}, 8'h01);
        chk(b_oe, 8'hFF);
        chk(b_o, 8'h05);
        chk(c_o, 8'h40);
        chk({7'h0, upro_plain}, 8'h00);
        foreach (fsel[i]) rd_reg(fsel[i], 8'hFF);
        results();
    end
endmodule : tb_top
